// file: design/trigger_delay_sequencer.sv
// trigger delay sequencer top with auto delay table and handshake pins
// Operation
// [RQ1] programmed delay accepted from zero to one hour in seconds
// [RQ2] automatic delay from function, range, integration and filter unless programmed
// [RQ3] delay reverts to automatic on reset or configure/measure command
// [RQ4] fixed delay is the same for every function and range
// [RQ5] delay inserted before every sample of a multi-sample trigger
// [RQ6] dc volts and amps: 1.5 ms at one cycle or more, else 1.0 ms
// [RQ7] resistance: 1.5/1.0 ms to 100k, 15/10 ms at 1M, 100 ms above
// [RQ8] ac with remote/single/external trigger: 7 s, 1 s, 600 ms by filter
// [RQ9] ac with front-panel auto trigger: 1.5 s, 200 ms, 100 ms by filter
// [RQ10] frequency/period: 1 s remote/single/external, zero with auto trigger
// [RQ11] one command loads seconds or min/max, another switches auto on/off
// [RQ12] hold latches new value after three successive readings in band
// [RQ13] hold band is one of four percentages, default 0.10%
// [RQ14] band is volatile and returns to 0.10% on reset
// [RQ15] stable value is frozen and beeps if beeper enabled
// [RQ16] hold suspended in remote and resumes in local
// [RQ17] one low pulse on measurement done after every measurement
// [RQ18] external low pulse triggers; in remote only with external source
// [RQ19] one external trigger during a reading is remembered and served after
// [RQ20] external triggers discarded for 20 ms after wait-for-trigger entry; code starts this window only on arming from idle
// [RQ21] trigger, delay, sample, done pulse, repeat until sample count exhausted
module trigger_delay_sequencer
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic IF_RESET_IN,
  input wire logic CONFIG_CMD_IN,
  input wire logic DELAY_LOAD_IN,
  input wire logic [1:0] DELAY_SEL_IN,
  input wire logic [11:0] DELAY_SEC_IN,
  input wire logic AUTO_LOAD_IN,
  input wire logic AUTO_ON_IN,
  input wire logic [2:0] FUNCTION_IN,
  input wire logic [2:0] RANGE_IN,
  input wire logic INTEGRATION_CYCLES_GE1_IN,
  input wire logic [1:0] AC_FILTER_IN,
  input wire logic FRONT_AUTO_TRIG_IN,
  input wire logic REMOTE_IN,
  input wire logic EXT_SOURCE_IN,
  input wire logic ARM_IN,
  input wire logic INT_TRIG_IN,
  input wire logic [15:0] SAMPLE_COUNT_IN,
  input wire logic EXT_TRIG_N_IN,
  input wire logic SAMPLE_DONE_IN,
  input wire logic [23:0] READING_IN,
  input wire logic HOLD_EN_IN,
  input wire logic BEEP_EN_IN,
  input wire logic BAND_LOAD_IN,
  input wire logic [1:0] BAND_SEL_IN,
  output logic SAMPLE_START_OUT,
  output logic MEASUREMENT_DONE_PULSE_N_OUT,
  output logic BUSY_OUT,
  output logic WAITING_OUT,
  output logic AUTO_DELAY_OUT,
  output logic [25:0] DELAY_TICKS_OUT,
  output logic [1:0] BAND_OUT,
  output logic [23:0] HELD_READING_OUT,
  output logic BEEP_OUT
);
  typedef enum {ST_IDLE, ST_WAIT, ST_DELAY, ST_SAMPLE} state_t;
  state_t state_q, state_d;
  logic [1:0] ext_sync_q, ext_sync_d;
  logic ext_prev_q, ext_prev_d;
  logic [12:0] div_q, div_d;
  logic tick;
  logic auto_q, auto_d;
  logic [25:0] fixed_q, fixed_d;
  logic [25:0] dly_q, dly_d;
  logic [15:0] left_q, left_d;
  logic [7:0] setup_q, setup_d;
  logic pend_q, pend_d;
  logic start_q, start_d;
  logic [2:0] pulse_q, pulse_d;
  logic [25:0] auto_val, cur_delay;
  logic ext_fall, ext_ok, fire, busy;
  logic cfg_reset;

  // automatic delay table, in 0.1 ms ticks
  function automatic logic [25:0] auto_delay(input logic [2:0] fn, input logic [2:0] rng,
      input logic ge1, input logic [1:0] filt, input logic fp_auto);
    logic [25:0] r;
    r = trig_delay_pkg::DLY_ZERO;
    case (fn)
      trig_delay_pkg::FN_DCV, trig_delay_pkg::FN_DCI:
        r = ge1 ? trig_delay_pkg::DLY_1P5_MS : trig_delay_pkg::DLY_1P0_MS; // [RQ6]
      trig_delay_pkg::FN_OHM2, trig_delay_pkg::FN_OHM4:
        if (rng < trig_delay_pkg::RNG_1M) // [RQ7]
          r = ge1 ? trig_delay_pkg::DLY_1P5_MS : trig_delay_pkg::DLY_1P0_MS;
        else if (rng == trig_delay_pkg::RNG_1M)
          r = ge1 ? trig_delay_pkg::DLY_15_MS : trig_delay_pkg::DLY_10_MS;
        else
          r = trig_delay_pkg::DLY_100_MS;
      trig_delay_pkg::FN_ACV, trig_delay_pkg::FN_ACI:
        if (fp_auto) // [RQ9]
        begin
          case (filt)
            trig_delay_pkg::FILT_SLOW: r = trig_delay_pkg::DLY_1P5_S;
            trig_delay_pkg::FILT_MED: r = trig_delay_pkg::DLY_200_MS;
            default: r = trig_delay_pkg::DLY_100_MS;
          endcase
        end
        else // [RQ8]
        begin
          case (filt)
            trig_delay_pkg::FILT_SLOW: r = trig_delay_pkg::DLY_7P0_S;
            trig_delay_pkg::FILT_MED: r = trig_delay_pkg::DLY_1P0_S;
            default: r = trig_delay_pkg::DLY_600_MS;
          endcase
        end
      trig_delay_pkg::FN_FREQ, trig_delay_pkg::FN_PER:
        r = fp_auto ? trig_delay_pkg::DLY_ZERO : trig_delay_pkg::DLY_1P0_S; // [RQ10]
      default:
        r = trig_delay_pkg::DLY_ZERO;
    endcase
    return r;
  endfunction : auto_delay

  assign cfg_reset = IF_RESET_IN | CONFIG_CMD_IN;
  assign tick = (div_q == 13'(trig_delay_pkg::TICK_CYCLES - 1));
  assign auto_val = auto_delay(FUNCTION_IN, RANGE_IN, INTEGRATION_CYCLES_GE1_IN,
                               AC_FILTER_IN, FRONT_AUTO_TRIG_IN & ~REMOTE_IN);
  assign cur_delay = auto_q ? auto_val : fixed_q; // [RQ2] [RQ4]
  assign ext_fall = ext_prev_q & ~ext_sync_q[1];
  // remote needs external source; local single/external listens outside the setup window [RQ18]
  assign ext_ok = ext_fall & (~REMOTE_IN | EXT_SOURCE_IN) & (setup_q == 8'h00); // [RQ20]
  assign busy = (state_q == ST_DELAY) | (state_q == ST_SAMPLE);
  assign fire = ext_ok | pend_q | INT_TRIG_IN;

  // pin sampler and tick divider
  always_comb
  begin
    ext_sync_d = {ext_sync_q[0], EXT_TRIG_N_IN};
    ext_prev_d = ext_sync_q[1];
    div_d = tick ? 13'h0000 : 13'(div_q + 13'h0001);
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      ext_sync_q <= 2'h3; // idle high, so no false edge after reset
      ext_prev_q <= 1'b1;
      div_q <= 13'h0000;
    end
    else
    begin
      ext_sync_q <= ext_sync_d;
      ext_prev_q <= ext_prev_d;
      div_q <= div_d;
    end
  end

  // delay setting
  always_comb
  begin
    auto_d = auto_q;
    fixed_d = fixed_q;
    if (cfg_reset)
      auto_d = 1'b1; // [RQ3]
    else if (DELAY_LOAD_IN) // [RQ11]
    begin
      auto_d = 1'b0;
      case (DELAY_SEL_IN)
        2'h1: fixed_d = trig_delay_pkg::DLY_ZERO;
        2'h2: fixed_d = trig_delay_pkg::DLY_MAX_TICKS;
        default:
          // clamp keeps the one hour ceiling [RQ1]
          fixed_d = (DELAY_SEC_IN > 12'(trig_delay_pkg::DLY_MAX_S)) ?
                    trig_delay_pkg::DLY_MAX_TICKS :
                    26'(26'(DELAY_SEC_IN) * trig_delay_pkg::DLY_1P0_S);
      endcase
    end
    else if (AUTO_LOAD_IN)
      auto_d = AUTO_ON_IN; // [RQ11]
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      auto_q <= 1'b1; // [RQ3]
      fixed_q <= 26'h000_0000;
    end
    else
    begin
      auto_q <= auto_d;
      fixed_q <= fixed_d;
    end
  end

  // done strobe; it restarts if a sample ends while it is still low
  always_comb
  begin
    if (state_q == ST_SAMPLE && SAMPLE_DONE_IN)
      pulse_d = 3'(trig_delay_pkg::PULSE_CYCLES); // [RQ17]
    else if (pulse_q != 3'h0)
      pulse_d = 3'(pulse_q - 3'h1);
    else
      pulse_d = 3'h0;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      pulse_q <= 3'h0;
    else
      pulse_q <= pulse_d;
  end

  // trigger sequencer
  always_comb
  begin
    state_d = state_q;
    dly_d = dly_q;
    left_d = left_q;
    pend_d = pend_q;
    start_d = 1'b0;
    setup_d = (setup_q != 8'h00 && tick) ? 8'(setup_q - 8'h01) : setup_q;
    if (busy && ext_ok)
      pend_d = 1'b1; // buffer one, later ones fold in [RQ19]
    case (state_q)
      ST_IDLE:
        if (ARM_IN)
        begin
          state_d = ST_WAIT;
          setup_d = trig_delay_pkg::SETUP_TICKS; // [RQ20]
          pend_d = 1'b0;
        end
      ST_WAIT:
        if (fire)
        begin
          state_d = ST_DELAY; // [RQ21]
          pend_d = 1'b0; // [RQ19]
          dly_d = cur_delay;
          left_d = (SAMPLE_COUNT_IN == 16'h0000) ? trig_delay_pkg::SAMPLE_ONE
                   : SAMPLE_COUNT_IN;
        end
      ST_DELAY:
        if (dly_q == 26'h000_0000)
        begin
          state_d = ST_SAMPLE;
          start_d = 1'b1;
        end
        else if (tick)
          dly_d = 26'(dly_q - 26'h000_0001);
      ST_SAMPLE:
        if (SAMPLE_DONE_IN)
        begin
          if (left_q == trig_delay_pkg::SAMPLE_ONE)
            state_d = ST_WAIT; // [RQ21]
          else
          begin
            left_d = 16'(left_q - 16'h0001);
            dly_d = cur_delay; // delay again before next sample [RQ5]
            state_d = ST_DELAY;
          end
        end
      default:
        state_d = ST_IDLE;
    endcase
    // an abort must not leave a start strobe or a buffered edge behind
    if (cfg_reset || (!ARM_IN && state_q == ST_WAIT))
    begin
      state_d = ST_IDLE;
      start_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q <= ST_IDLE;
      dly_q <= 26'h000_0000;
      left_q <= 16'h0000;
      setup_q <= 8'h00;
      pend_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dly_q <= dly_d;
      left_q <= left_d;
      setup_q <= setup_d;
      pend_q <= pend_d;
      start_q <= start_d;
    end
  end

  hold_detector u_hold
  (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .band_reset_in(IF_RESET_IN),
    .band_load_in(BAND_LOAD_IN),
    .band_sel_in(BAND_SEL_IN),
    .active_in(HOLD_EN_IN & ~REMOTE_IN), // [RQ16]
    .beep_en_in(BEEP_EN_IN),
    .sample_valid_in(SAMPLE_DONE_IN),
    .sample_in(READING_IN),
    .band_out(BAND_OUT),
    .held_out(HELD_READING_OUT),
    .beep_out(BEEP_OUT)
  );

  assign SAMPLE_START_OUT = start_q;
  assign MEASUREMENT_DONE_PULSE_N_OUT = (pulse_q == 3'h0); // [RQ17]
  assign BUSY_OUT = busy;
  assign WAITING_OUT = (state_q == ST_WAIT);
  assign AUTO_DELAY_OUT = auto_q;
  assign DELAY_TICKS_OUT = cur_delay;
endmodule : trigger_delay_sequencer

// file: common/trig_delay_pkg.sv
// constants and codes for the trigger delay sequencer
package trig_delay_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 10_000;
  // delay figures in units of 0.1 ms, except DLY_MAX_S in seconds
  localparam int unsigned DLY_MAX_S = 3600;
  localparam logic [25:0] DLY_MAX_TICKS = 26'(DLY_MAX_S * 10_000);
  localparam logic [25:0] DLY_1P0_MS = 26'h000_000A;
  localparam logic [25:0] DLY_1P5_MS = 26'h000_000F;
  localparam logic [25:0] DLY_10_MS = 26'h000_0064;
  localparam logic [25:0] DLY_15_MS = 26'h000_0096;
  localparam logic [25:0] DLY_100_MS = 26'h000_03E8;
  localparam logic [25:0] DLY_200_MS = 26'h000_07D0;
  localparam logic [25:0] DLY_600_MS = 26'h000_1770;
  localparam logic [25:0] DLY_1P0_S = 26'h000_2710;
  localparam logic [25:0] DLY_1P5_S = 26'h000_3A98;
  localparam logic [25:0] DLY_7P0_S = 26'h001_1170;
  localparam logic [25:0] DLY_ZERO = 26'h000_0000;
  localparam int unsigned SETUP_MS = 20;
  localparam logic [7:0] SETUP_TICKS = 8'(SETUP_MS * 10);
  localparam logic [15:0] SAMPLE_ONE = 16'h0001;
  localparam int unsigned PULSE_CYCLES = 4;
  localparam logic [1:0] BAND_DEFAULT = 2'h1;
  localparam logic [1:0] HOLD_COUNT = 2'h3;
  // function codes
  localparam logic [2:0] FN_DCV = 3'h0;
  localparam logic [2:0] FN_DCI = 3'h1;
  localparam logic [2:0] FN_OHM2 = 3'h2;
  localparam logic [2:0] FN_OHM4 = 3'h3;
  localparam logic [2:0] FN_ACV = 3'h4;
  localparam logic [2:0] FN_ACI = 3'h5;
  localparam logic [2:0] FN_FREQ = 3'h6;
  localparam logic [2:0] FN_PER = 3'h7;
  // resistance range codes: 0=100 ohm .. 6=100 Mohm
  localparam logic [2:0] RNG_1M = 3'h4;
  // ac filter codes
  localparam logic [1:0] FILT_SLOW = 2'h0;
  localparam logic [1:0] FILT_MED = 2'h1;
endpackage : trig_delay_pkg

// file: design/hold_detector.sv
// reading-hold stability detector
module hold_detector
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic band_reset_in,
  input wire logic band_load_in,
  input wire logic [1:0] band_sel_in,
  input wire logic active_in,
  input wire logic beep_en_in,
  input wire logic sample_valid_in,
  input wire logic [23:0] sample_in,
  output logic [1:0] band_out,
  output logic [23:0] held_out,
  output logic beep_out
);
  logic [1:0] band_q, band_d;
  logic [23:0] ref_q, ref_d, held_q, held_d;
  logic [1:0] cnt_q, cnt_d;
  logic beep_q, beep_d;
  logic [23:0] mag, diff, lim;

  function automatic logic [23:0] abs24(input logic [23:0] v);
    abs24 = v[23] ? 24'(-v) : v;
  endfunction : abs24

  always_comb
  begin
    band_d = band_q;
    ref_d = ref_q;
    held_d = held_q;
    cnt_d = cnt_q;
    beep_d = 1'b0;
    mag = abs24(ref_q);
    diff = abs24(24'(sample_in - ref_q));
    case (band_q) // band as fraction of reading, shift approximations [RQ13]
      2'h0: lim = mag >> 13;
      2'h1: lim = mag >> 10;
      2'h2: lim = mag >> 7;
      default: lim = mag >> 3;
    endcase
    if (band_reset_in)
      band_d = trig_delay_pkg::BAND_DEFAULT; // [RQ14]
    else if (band_load_in)
      band_d = band_sel_in; // [RQ13]
    if (sample_valid_in && active_in) // suspended in remote [RQ16]
    begin
      if (cnt_q != 2'h0 && diff <= lim)
      begin
        if (cnt_q + 2'h1 == trig_delay_pkg::HOLD_COUNT) // three in band [RQ12]
        begin
          cnt_d = 2'h0;
          if (sample_in != held_q)
          begin
            held_d = sample_in; // [RQ15]
            beep_d = beep_en_in; // [RQ15]
          end
        end
        else
          cnt_d = cnt_q + 2'h1;
      end
      else
      begin
        ref_d = sample_in;
        cnt_d = 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      band_q <= trig_delay_pkg::BAND_DEFAULT;
      ref_q <= 24'h00_0000;
      held_q <= 24'h00_0000;
      cnt_q <= 2'h0;
      beep_q <= 1'b0;
    end
    else
    begin
      band_q <= band_d;
      ref_q <= ref_d;
      held_q <= held_d;
      cnt_q <= cnt_d;
      beep_q <= beep_d;
    end
  end

  assign band_out = band_q;
  assign held_out = held_q;
  assign beep_out = beep_q;
endmodule : hold_detector

// file: tb/trig_delay_sva.sv
// assertion checker for the trigger delay sequencer ports
module trig_delay_sva
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic IF_RESET_IN,
  input wire logic CONFIG_CMD_IN,
  input wire logic DELAY_LOAD_IN,
  input wire logic [2:0] FUNCTION_IN,
  input wire logic INTEGRATION_CYCLES_GE1_IN,
  input wire logic SAMPLE_DONE_IN,
  input wire logic BEEP_EN_IN,
  input wire logic SAMPLE_START_OUT,
  input wire logic MEASUREMENT_DONE_PULSE_N_OUT,
  input wire logic BUSY_OUT,
  input wire logic AUTO_DELAY_OUT,
  input wire logic [25:0] DELAY_TICKS_OUT,
  input wire logic [1:0] BAND_OUT,
  input wire logic [23:0] HELD_READING_OUT,
  input wire logic BEEP_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // done strobe is low four cycles, then released
  sequence done_low_s;
    !MEASUREMENT_DONE_PULSE_N_OUT [*4] ##1 MEASUREMENT_DONE_PULSE_N_OUT;
  endsequence
  chk_start_one_cycle: assert property (SAMPLE_START_OUT |=> !SAMPLE_START_OUT)
    else $error("sample start wider than one cycle");
  chk_start_when_busy: assert property (SAMPLE_START_OUT |-> BUSY_OUT)
    else $error("sample start outside a sequence");
  chk_done_cause: assert property ($fell(MEASUREMENT_DONE_PULSE_N_OUT) |-> $past(SAMPLE_DONE_IN))
    else $error("done pulse without a finished sample");
  chk_done_width: assert property ($fell(MEASUREMENT_DONE_PULSE_N_OUT) |-> done_low_s)
    else $error("done pulse width wrong");
  chk_auto_revert: assert property ((IF_RESET_IN || CONFIG_CMD_IN) |=> AUTO_DELAY_OUT)
    else $error("delay not back to automatic");
  chk_band_revert: assert property (IF_RESET_IN |=> BAND_OUT == trig_delay_pkg::BAND_DEFAULT)
    else $error("band not back to default");
  chk_fixed_load: assert property (DELAY_LOAD_IN && !IF_RESET_IN && !CONFIG_CMD_IN
    |=> !AUTO_DELAY_OUT)
    else $error("loaded delay left automatic on");
  chk_dc_auto: assert property (AUTO_DELAY_OUT && FUNCTION_IN == trig_delay_pkg::FN_DCV
    |-> DELAY_TICKS_OUT == (INTEGRATION_CYCLES_GE1_IN ? trig_delay_pkg::DLY_1P5_MS
    : trig_delay_pkg::DLY_1P0_MS))
    else $error("dc automatic delay wrong");
  chk_fixed_same: assert property (!AUTO_DELAY_OUT && !$past(AUTO_DELAY_OUT)
    && !$past(DELAY_LOAD_IN) |-> $stable(DELAY_TICKS_OUT))
    else $error("fixed delay moved with settings");
  chk_max_delay: assert property (DELAY_TICKS_OUT <= trig_delay_pkg::DLY_MAX_TICKS)
    else $error("delay above one hour");
  chk_beep_enable: assert property (BEEP_OUT |-> $past(BEEP_EN_IN))
    else $error("beep while beeper disabled");
  chk_held_cause: assert property ($changed(HELD_READING_OUT)
    |-> $past(SAMPLE_DONE_IN) || $past(SAMPLE_DONE_IN, 2))
    else $error("held value changed without a reading");
endmodule : trig_delay_sva

// file: tb/switch_model.sv
// switching device model that answers each done pulse with a trigger
module switch_model
(
  input wire logic clk_in,
  input wire logic done_n_in,
  input wire logic en_in,
  output logic trig_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // pin has a pull-up, so released means high
  initial
  begin
    trig_n_out = 1'b1;
    forever
    begin
      @(negedge done_n_in);
      if (en_in)
      begin
        repeat (2) @(posedge clk_in);
        trig_n_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        trig_n_out <= 1'b1;
      end
    end
  end
endmodule : switch_model

// file: tb/trigger_delay_sequencer_tb_top.sv
// self-checking bench for the trigger delay sequencer
module trigger_delay_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, if_rst, cfg, dly_ld, auto_ld, auto_on, ge1, fp_auto, remote, arm;
  logic int_trig, sdone, hold_en, beep_en, band_ld, sw_en, ext_src;
  logic ext_n, start, done_n, busy, waiting, auto_o, beep;
  logic [1:0] dly_sel, filt, band_sel, band;
  logic [2:0] fn, rng;
  logic [11:0] dly_sec;
  logic [15:0] scount;
  logic [23:0] rdg, held;
  logic [23:0] rq [4];
  logic [25:0] ticks;
  int mismatches, cmp_count, starts, dones, beeps, exts;

  trigger_delay_sequencer u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .IF_RESET_IN(if_rst),
    .CONFIG_CMD_IN(cfg), .DELAY_LOAD_IN(dly_ld), .DELAY_SEL_IN(dly_sel),
    .DELAY_SEC_IN(dly_sec), .AUTO_LOAD_IN(auto_ld), .AUTO_ON_IN(auto_on),
    .FUNCTION_IN(fn), .RANGE_IN(rng), .INTEGRATION_CYCLES_GE1_IN(ge1),
    .AC_FILTER_IN(filt), .FRONT_AUTO_TRIG_IN(fp_auto), .REMOTE_IN(remote),
    .EXT_SOURCE_IN(ext_src), .ARM_IN(arm), .INT_TRIG_IN(int_trig), .SAMPLE_COUNT_IN(scount),
    .EXT_TRIG_N_IN(ext_n), .SAMPLE_DONE_IN(sdone), .READING_IN(rdg), .HOLD_EN_IN(hold_en),
    .BEEP_EN_IN(beep_en), .BAND_LOAD_IN(band_ld), .BAND_SEL_IN(band_sel),
    .SAMPLE_START_OUT(start), .MEASUREMENT_DONE_PULSE_N_OUT(done_n), .BUSY_OUT(busy),
    .WAITING_OUT(waiting), .AUTO_DELAY_OUT(auto_o), .DELAY_TICKS_OUT(ticks),
    .BAND_OUT(band), .HELD_READING_OUT(held), .BEEP_OUT(beep));
  switch_model u_sw (.clk_in(clk), .done_n_in(done_n), .en_in(sw_en), .trig_n_out(ext_n));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // counted mid-cycle, where the registered strobes have settled
  always @(negedge clk)
  begin
    if (start === 1'b1) starts++;
    if (beep === 1'b1) beeps++;
  end
  always @(negedge done_n) dones++;
  always @(negedge ext_n) exts++;

  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse

  // bounded wait, a timeout shows up as a mismatch
  task automatic wait_on(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    cmp(26'(s), 26'(v));
  endtask : wait_on

  // arm, fire one internal trigger, answer each sample as the adc would
  task automatic run(input int n);
    @(negedge clk);
    scount = 16'(n);
    arm = 1'b1;
    wait_on(waiting, 1'b1);
    pulse(int_trig);
    for (int i = 0; i < n; i++)
    begin
      wait_on(start, 1'b1);
      repeat (4) @(negedge clk);
      rdg = rq[i];
      sdone = 1'b1;
      @(negedge clk);
      sdone = 1'b0;
    end
    wait_on(busy, 1'b0);
    repeat (20) @(negedge clk);
    arm = 1'b0;
  endtask : run

  task automatic ac(input logic [2:0] f, input logic [2:0] r, input logic g,
    input logic [1:0] fl, input logic fa, input logic [25:0] exp);
    @(negedge clk);
    fn = f;
    rng = r;
    ge1 = g;
    filt = fl;
    fp_auto = fa;
    #1 cmp(ticks, exp);
  endtask : ac

  task automatic t_auto();
    ac(3'h0, 3'h0, 1'h1, 2'h0, 1'h0, trig_delay_pkg::DLY_1P5_MS);
    ac(3'h1, 3'h0, 1'h0, 2'h0, 1'h0, trig_delay_pkg::DLY_1P0_MS);
    ac(3'h2, 3'h3, 1'h1, 2'h0, 1'h0, trig_delay_pkg::DLY_1P5_MS);
    ac(3'h3, 3'h4, 1'h0, 2'h0, 1'h0, trig_delay_pkg::DLY_10_MS);
    ac(3'h2, 3'h4, 1'h1, 2'h0, 1'h0, trig_delay_pkg::DLY_15_MS);
    ac(3'h3, 3'h5, 1'h0, 2'h0, 1'h0, trig_delay_pkg::DLY_100_MS);
    ac(3'h4, 3'h0, 1'h1, 2'h0, 1'h0, trig_delay_pkg::DLY_7P0_S);
    ac(3'h5, 3'h0, 1'h1, 2'h1, 1'h0, trig_delay_pkg::DLY_1P0_S);
    ac(3'h4, 3'h0, 1'h1, 2'h2, 1'h0, trig_delay_pkg::DLY_600_MS);
    ac(3'h4, 3'h0, 1'h1, 2'h0, 1'h1, trig_delay_pkg::DLY_1P5_S);
    ac(3'h5, 3'h0, 1'h1, 2'h1, 1'h1, trig_delay_pkg::DLY_200_MS);
    ac(3'h4, 3'h0, 1'h1, 2'h3, 1'h1, trig_delay_pkg::DLY_100_MS);
    ac(3'h6, 3'h0, 1'h1, 2'h0, 1'h0, trig_delay_pkg::DLY_1P0_S);
    ac(3'h7, 3'h0, 1'h1, 2'h0, 1'h1, trig_delay_pkg::DLY_ZERO);
    @(negedge clk) remote = 1'b1;
    #1 cmp(ticks, trig_delay_pkg::DLY_1P0_S);
    @(negedge clk) remote = 1'b0;
    $display("test auto delay done");
  endtask : t_auto

  task automatic t_prog();
    @(negedge clk) dly_sec = 12'h005;
    pulse(dly_ld);
    cmp(26'(auto_o), 26'h000_0000);
    cmp(ticks, 26'h000_C350);
    fn = 3'h2;
    #1 cmp(ticks, 26'h000_C350);
    @(negedge clk) dly_sec = 12'hFA0;
    pulse(dly_ld);
    cmp(ticks, trig_delay_pkg::DLY_MAX_TICKS);
    auto_on = 1'b1;
    pulse(auto_ld);
    cmp(26'(auto_o), 26'h000_0001);
    auto_on = 1'b0;
    pulse(auto_ld);
    pulse(cfg);
    cmp(26'(auto_o), 26'h000_0001);
    dly_sel = 2'h1;
    pulse(dly_ld);
    cmp(ticks, trig_delay_pkg::DLY_ZERO);
    $display("test programmed delay done");
  endtask : t_prog

  // switch answers every done pulse, all inside the setup window
  task automatic t_multi();
    starts = 0;
    dones = 0;
    exts = 0;
    sw_en = 1'b1;
    rq = '{24'h00_0001, 24'h00_0002, 24'h00_0003, 24'h00_0004};
    run(3);
    sw_en = 1'b0;
    cmp(26'(starts), 26'h000_0003);
    cmp(26'(dones), 26'h000_0003);
    cmp(26'(exts != 0), 26'h000_0001);
    $display("test multi sample done");
  endtask : t_multi

  task automatic t_hold();
    hold_en = 1'b1;
    beep_en = 1'b1;
    beeps = 0;
    rq = '{24'h00_03E8, 24'h00_1388, 24'h00_1388, 24'h00_1388};
    run(4);
    cmp(26'(held), 26'h000_1388);
    cmp(26'(beeps), 26'h000_0001);
    remote = 1'b1;
    rq = '{24'h00_1B58, 24'h00_1B58, 24'h00_1B58, 24'h00_1B58};
    run(3);
    cmp(26'(held), 26'h000_1388);
    remote = 1'b0;
    run(3);
    cmp(26'(held), 26'h000_1B58);
    $display("test hold done");
  endtask : t_hold

  task automatic t_band();
    for (int s = 0; s < 4; s++)
    begin
      band_sel = 2'(s);
      pulse(band_ld);
      cmp(26'(band), 26'(s));
    end
    pulse(if_rst);
    cmp(26'(band), 26'h000_0001);
    cmp(26'(auto_o), 26'h000_0001);
    $display("test band done");
  endtask : t_band

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    {if_rst, cfg, dly_ld, auto_ld, auto_on, ge1, fp_auto, remote, arm} = '0;
    {int_trig, sdone, hold_en, beep_en, band_ld, sw_en} = '0;
    ext_src = 1'b1;
    {dly_sel, filt, band_sel, dly_sec, fn, rng, scount, rdg} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    cmp(26'(auto_o), 26'h000_0001);
    cmp(26'(band), 26'h000_0001);
    cmp(26'(done_n), 26'h000_0001);
    $display("test reset done");
    t_auto();
    t_prog();
    t_multi();
    t_hold();
    t_band();
    summarize();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial
  begin
    #2_000_000;
    mismatches++;
    summarize();
  end
endmodule : trigger_delay_sequencer_tb_top

bind trigger_delay_sequencer trig_delay_sva u_sva (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .IF_RESET_IN(IF_RESET_IN), .CONFIG_CMD_IN(CONFIG_CMD_IN), .DELAY_LOAD_IN(DELAY_LOAD_IN),
  .FUNCTION_IN(FUNCTION_IN), .INTEGRATION_CYCLES_GE1_IN(INTEGRATION_CYCLES_GE1_IN),
  .SAMPLE_DONE_IN(SAMPLE_DONE_IN), .BEEP_EN_IN(BEEP_EN_IN), .SAMPLE_START_OUT(SAMPLE_START_OUT),
  .MEASUREMENT_DONE_PULSE_N_OUT(MEASUREMENT_DONE_PULSE_N_OUT), .BUSY_OUT(BUSY_OUT),
  .AUTO_DELAY_OUT(AUTO_DELAY_OUT), .DELAY_TICKS_OUT(DELAY_TICKS_OUT), .BAND_OUT(BAND_OUT),
  .HELD_READING_OUT(HELD_READING_OUT), .BEEP_OUT(BEEP_OUT));
